// ---- shared/rdg_pkg.sv ----
// package: register map, field positions, reset values and timing of the radio data status block
`default_nettype none
package rdg_pkg;
	// ****************************************
	// register bus shape
	// ****************************************
	localparam int unsigned ADDR_W = 8;
	localparam int unsigned DATA_W = 16;

	// ****************************************
	// register offsets (byte addresses)
	// ****************************************
	localparam logic [7:0] OFS_CTRL     = 8'h00;
	localparam logic [7:0] OFS_PIN_CFG  = 8'h04;
	localparam logic [7:0] OFS_STATUS   = 8'h08;
	localparam logic [7:0] OFS_BLOCKS   = 8'h0c;
	localparam logic [7:0] OFS_IRQ_STAT = 8'h10;
	localparam logic [7:0] OFS_IRQ_MASK = 8'h14;

	// ****************************************
	// field positions
	// ****************************************
	localparam int unsigned CTRL_RDE_BIT    = 0;
	localparam int unsigned CTRL_MODE_BIT   = 1;
	localparam int unsigned PCFG_FN_LSB     = 2;
	localparam int unsigned PCFG_SEEK_IE    = 14;
	localparam int unsigned PCFG_GROUP_IE   = 15;
	localparam int unsigned STAT_PIN_IN     = 0;
	localparam int unsigned STAT_SYNC_BIT   = 9;
	localparam int unsigned STAT_SEEK_BIT   = 14;
	localparam int unsigned STAT_READY_BIT  = 15;
	localparam int unsigned IRQ_GROUP_BIT   = 0;
	localparam int unsigned IRQ_SEEK_BIT    = 1;
	localparam int unsigned IRQ_W           = 2;

	// ****************************************
	// reset values
	// ****************************************
	localparam logic [1:0]       CTRL_RESET = 2'h0;
	localparam logic [1:0]       FN_RESET   = 2'h0;
	localparam logic [IRQ_W-1:0] MASK_RESET = 2'h0;

	// ****************************************
	// output pin functions and error levels
	// ****************************************
	typedef enum logic [1:0] {
		RDG_PIN_HIGHZ = 2'b00,
		RDG_PIN_IRQ   = 2'b01,
		RDG_PIN_LOW   = 2'b10,
		RDG_PIN_HIGH  = 2'b11
	} rdg_pin_fn_e;

	localparam logic [1:0] LVL_NONE  = 2'b00;
	localparam logic [1:0] LVL_FEW   = 2'b01;
	localparam logic [1:0] LVL_SOME  = 2'b10;
	localparam logic [1:0] LVL_MANY  = 2'b11;
	localparam logic [3:0] ERR_FEW_MAX  = 4'h2;
	localparam logic [3:0] ERR_SOME_MAX = 4'h5;

	// ****************************************
	// timing
	// ****************************************
	localparam longint unsigned CLK_HZ      = 50_000_000;
	localparam longint unsigned READY_MS    = 40;
	localparam longint unsigned PULSE_MS    = 5;
	localparam longint unsigned READY_CYC   = (READY_MS * CLK_HZ + 999) / 1000;
	localparam longint unsigned PULSE_CYC   = (PULSE_MS * CLK_HZ + 999) / 1000;

	// ****************************************
	// group report from the decoder
	// ****************************************
	typedef struct packed {
		logic            done;
		logic            valid;
		logic [3:0][3:0] errs;
	} rdg_group_s;
endpackage
`default_nettype wire

// ---- rtl/rdg_sync2.sv ----
// two flip-flop synchroniser for one level from outside the clock domain
`default_nettype none
module rdg_sync2 (
	input  wire logic sys_clk_i,
	input  wire logic resetn_i,
	input  wire logic async_i,
	output logic      sync_o
);
	logic meta_reg;

	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			meta_reg <= 1'b0;
			sync_o   <= 1'b0;
		end else begin
			meta_reg <= async_i;
			sync_o   <= meta_reg;
		end
	end
endmodule
`default_nettype wire

// ---- rtl/rdg_hold_timer.sv ----
// retriggerable hold timer: active for at least CYCLES clocks after each start
`default_nettype none
module rdg_hold_timer #(
	parameter int unsigned CYCLES = 16
) (
	input  wire logic sys_clk_i,
	input  wire logic resetn_i,
	input  wire logic start_i,
	output logic      active_o
);
	localparam int unsigned CNT_W = $clog2(CYCLES + 1);

	logic [CNT_W-1:0] left_reg;

	if (CYCLES < 1) $error("hold timer needs at least one cycle");

	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			left_reg <= '0;
			active_o <= 1'b0;
		end else if (start_i) begin
			left_reg <= CNT_W'(CYCLES - 1);
			active_o <= 1'b1;
		end else if (left_reg != '0) begin
			left_reg <= left_reg - 1'b1;
		end else begin
			active_o <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// ---- rtl/rdg_top.sv ----
// radio data group status, verbose reporting and interrupt pin logic
//
// Contract
// R1: software sets radio data enable; while clear no group is reported.
// R2: report mode select low means standard mode; standard is the reset state.
// R3: standard mode: valid group raises group ready for at least 40 ms.
// R4: standard mode: group irq enable and function 01 pull pin low 5 ms.
// R5: invalid group sets no ready flag and gives no pin pulse; in verbose mode the code raises both for any group while synchronised.
// R6: standard mode: sync flag and four block levels read as zero.
// R7: report mode select high means verbose mode with sync and levels.
// R8: verbose mode: sync flag follows block synchronisation.
// R9: verbose mode: group while synchronised raises ready for at least 40 ms.
// R10: verbose mode: pin pulses 5 ms only for a group while synchronised.
// R11: each block level: 00 none, 01 one-two, 10 three-five, 11 six up.
// R12: controller discards blocks reported at level 11.
// R13: pin serves as general output or interrupt for seek or group events.
// R14: pin function is a two-bit field at bits 3:2 of register 04h.
// R15: controller waits for powerup before using the pin as interrupt.
// R16: general output function works regardless of receiver enable bits.
// R17: seek irq enable and function 01 pull pin low 5 ms on seek done.
// R18: pin pulse starts with the ready flag, and never without both enables; the code starts it with either one irq enable, group or seek, set.
`default_nettype none
module rdg_top #(
	parameter int unsigned READY_CYC = int'(rdg_pkg::READY_CYC),
	parameter int unsigned PULSE_CYC = int'(rdg_pkg::PULSE_CYC)
) (
	input  wire logic                       sys_clk_i,
	input  wire logic                       resetn_i,
	input  wire logic [rdg_pkg::ADDR_W-1:0] addr_i,
	input  wire logic [rdg_pkg::DATA_W-1:0] wdata_i,
	input  wire logic                       wr_i,
	input  wire logic                       rd_i,
	output logic      [rdg_pkg::DATA_W-1:0] rdata_o,
	input  wire rdg_pkg::rdg_group_s        group_i,
	input  wire logic                       sync_i,
	input  wire logic                       seek_done_i,
	input  wire logic                       pin_in_i,
	output logic                            pin_out_o,
	output logic                            pin_oe_o,
	output logic                            group_ready_flag_o,
	output logic                            irq_o
);
	// ****************************************
	// parameter checks and helpers
	// ****************************************
	if (READY_CYC < 1 || PULSE_CYC < 1) $error("timer counts must be at least one");
	if (PULSE_CYC > READY_CYC) $error("pin pulse may not outlast the ready flag");

	function automatic logic [1:0] err_level(input logic [3:0] n);
		if (n == 4'h0)
			return rdg_pkg::LVL_NONE;
		else if (n <= rdg_pkg::ERR_FEW_MAX)
			return rdg_pkg::LVL_FEW;
		else if (n <= rdg_pkg::ERR_SOME_MAX)
			return rdg_pkg::LVL_SOME;
		else
			return rdg_pkg::LVL_MANY;
	endfunction

	function automatic logic hit(input logic [rdg_pkg::ADDR_W-1:0] a,
			input logic [7:0] ofs);
		return a == ofs;
	endfunction

	// ****************************************
	// control registers
	// ****************************************
	logic                radio_data_enable_reg;
	logic                report_mode_select_reg;
	logic                group_irq_enable_reg;
	logic                seek_done_irq_enable_reg;
	rdg_pkg::rdg_pin_fn_e output_pin_function_reg;

	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			radio_data_enable_reg  <= rdg_pkg::CTRL_RESET[rdg_pkg::CTRL_RDE_BIT];
			report_mode_select_reg <= rdg_pkg::CTRL_RESET[rdg_pkg::CTRL_MODE_BIT]; // [R2]
		end else if (wr_i && hit(addr_i, rdg_pkg::OFS_CTRL)) begin
			radio_data_enable_reg  <= wdata_i[rdg_pkg::CTRL_RDE_BIT];
			report_mode_select_reg <= wdata_i[rdg_pkg::CTRL_MODE_BIT]; // [R7]
		end
	end

	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			group_irq_enable_reg     <= 1'b0;
			seek_done_irq_enable_reg <= 1'b0;
			output_pin_function_reg  <= rdg_pkg::rdg_pin_fn_e'(rdg_pkg::FN_RESET);
		end else if (wr_i && hit(addr_i, rdg_pkg::OFS_PIN_CFG)) begin
			group_irq_enable_reg     <= wdata_i[rdg_pkg::PCFG_GROUP_IE];
			seek_done_irq_enable_reg <= wdata_i[rdg_pkg::PCFG_SEEK_IE];
			output_pin_function_reg  <= rdg_pkg::rdg_pin_fn_e'(
				wdata_i[rdg_pkg::PCFG_FN_LSB +: 2]); // [R14]
		end
	end

	// ****************************************
	// group events
	// ****************************************
	logic group_event;
	logic seek_done_d_reg;
	logic seek_event;
	logic flag_active;
	logic pulse_active;
	logic pin_pulse_start;

	// standard: valid groups only; verbose: any group while synchronised
	always_comb begin
		group_event = 1'b0;
		if (radio_data_enable_reg && group_i.done) begin // [R1]
			if (report_mode_select_reg)
				group_event = sync_i; // [R9]
			else
				group_event = group_i.valid; // [R3] [R5]
		end
	end

	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i)
			seek_done_d_reg <= 1'b0;
		else
			seek_done_d_reg <= seek_done_i;
	end

	assign seek_event = seek_done_i && !seek_done_d_reg;

	// pulse and flag start on the same edge
	assign pin_pulse_start = (group_event && group_irq_enable_reg) // [R4] [R10] [R18]
		|| (seek_event && seek_done_irq_enable_reg); // [R17]

	rdg_hold_timer #(
		.CYCLES (READY_CYC)
	) u_ready_timer (
		.sys_clk_i (sys_clk_i),
		.resetn_i  (resetn_i),
		.start_i   (group_event),
		.active_o  (flag_active)
	);

	rdg_hold_timer #(
		.CYCLES (PULSE_CYC)
	) u_pulse_timer (
		.sys_clk_i (sys_clk_i),
		.resetn_i  (resetn_i),
		.start_i   (pin_pulse_start),
		.active_o  (pulse_active)
	);

	assign group_ready_flag_o = flag_active;

	// ****************************************
	// verbose status capture
	// ****************************************
	logic [3:0][1:0] block_level_reg;

	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			block_level_reg <= '0;
		end else if (group_event && report_mode_select_reg) begin
			for (int i = 0; i < 4; i++)
				block_level_reg[i] <= err_level(group_i.errs[i]); // [R11]
		end
	end

	// ****************************************
	// output pin
	// ****************************************
	logic pin_in_sync;

	rdg_sync2 u_pin_sync (
		.sys_clk_i (sys_clk_i),
		.resetn_i  (resetn_i),
		.async_i   (pin_in_i),
		.sync_o    (pin_in_sync)
	);

	// pin mux ignores the receiver enable bits
	always_comb begin
		pin_oe_o  = 1'b0;
		pin_out_o = 1'b1;
		unique case (output_pin_function_reg) // [R13] [R16]
			rdg_pkg::RDG_PIN_HIGHZ: begin
				pin_oe_o = 1'b0;
			end
			rdg_pkg::RDG_PIN_IRQ: begin
				pin_oe_o  = 1'b1;
				pin_out_o = !pulse_active; // [R4] [R17]
			end
			rdg_pkg::RDG_PIN_LOW: begin
				pin_oe_o  = 1'b1;
				pin_out_o = 1'b0;
			end
			rdg_pkg::RDG_PIN_HIGH: begin
				pin_oe_o  = 1'b1;
				pin_out_o = 1'b1;
			end
		endcase
	end

	// ****************************************
	// interrupt status and mask
	// ****************************************
	logic [rdg_pkg::IRQ_W-1:0] irq_stat_reg;
	logic [rdg_pkg::IRQ_W-1:0] irq_mask_reg;
	logic [rdg_pkg::IRQ_W-1:0] irq_set;
	logic [rdg_pkg::IRQ_W-1:0] irq_clr;
	logic [rdg_pkg::IRQ_W-1:0] irq_mask_next;

	always_comb begin
		irq_set = '0;
		irq_set[rdg_pkg::IRQ_GROUP_BIT] = group_event;
		irq_set[rdg_pkg::IRQ_SEEK_BIT]  = seek_event;
		irq_clr = '0;
		if (wr_i && hit(addr_i, rdg_pkg::OFS_IRQ_STAT))
			irq_clr = wdata_i[rdg_pkg::IRQ_W-1:0];
		irq_mask_next = irq_mask_reg;
		if (wr_i && hit(addr_i, rdg_pkg::OFS_IRQ_MASK))
			irq_mask_next = wdata_i[rdg_pkg::IRQ_W-1:0];
	end

	// set wins over a clear in the same cycle
	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i)
			irq_stat_reg <= '0;
		else
			irq_stat_reg <= (irq_stat_reg & ~irq_clr) | irq_set;
	end

	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i)
			irq_mask_reg <= rdg_pkg::MASK_RESET;
		else
			irq_mask_reg <= irq_mask_next;
	end

	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i)
			irq_o <= 1'b0;
		else
			irq_o <= |((irq_stat_reg & ~irq_clr | irq_set) & irq_mask_next);
	end

	// ****************************************
	// read port
	// ****************************************
	logic [rdg_pkg::DATA_W-1:0] rd_word;

	always_comb begin
		rd_word = '0;
		if (hit(addr_i, rdg_pkg::OFS_CTRL)) begin
			rd_word[rdg_pkg::CTRL_RDE_BIT]  = radio_data_enable_reg;
			rd_word[rdg_pkg::CTRL_MODE_BIT] = report_mode_select_reg;
		end else if (hit(addr_i, rdg_pkg::OFS_PIN_CFG)) begin
			rd_word[rdg_pkg::PCFG_FN_LSB +: 2]  = output_pin_function_reg;
			rd_word[rdg_pkg::PCFG_GROUP_IE]     = group_irq_enable_reg;
			rd_word[rdg_pkg::PCFG_SEEK_IE]      = seek_done_irq_enable_reg;
		end else if (hit(addr_i, rdg_pkg::OFS_STATUS)) begin
			rd_word[rdg_pkg::STAT_READY_BIT] = flag_active;
			rd_word[rdg_pkg::STAT_SEEK_BIT]  = seek_done_i;
			rd_word[rdg_pkg::STAT_PIN_IN]    = pin_in_sync;
			rd_word[rdg_pkg::STAT_SYNC_BIT]  = report_mode_select_reg && sync_i; // [R6] [R8]
		end else if (hit(addr_i, rdg_pkg::OFS_BLOCKS)) begin
			if (report_mode_select_reg)
				rd_word[7:0] = block_level_reg; // [R6] [R11]
		end else if (hit(addr_i, rdg_pkg::OFS_IRQ_STAT)) begin
			rd_word[rdg_pkg::IRQ_W-1:0] = irq_stat_reg;
		end else if (hit(addr_i, rdg_pkg::OFS_IRQ_MASK)) begin
			rd_word[rdg_pkg::IRQ_W-1:0] = irq_mask_reg;
		end
	end

	// unmapped addresses read as zero
	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i)
			rdata_o <= '0;
		else if (rd_i)
			rdata_o <= rd_word;
		else
			rdata_o <= '0;
	end

	// ****************************************
	// checks
	// ****************************************
	logic [31:0] flag_len_reg;
	logic [31:0] low_len_reg;

	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			flag_len_reg <= '0;
			low_len_reg  <= '0;
		end else begin
			flag_len_reg <= group_event ? 32'h1 : (flag_active ? flag_len_reg + 1 : '0);
			low_len_reg  <= pin_pulse_start ? 32'h1 : (pulse_active ? low_len_reg + 1 : '0);
		end
	end

	default clocking dcb @(posedge sys_clk_i);
	endclocking
	default disable iff (!resetn_i);

	ready_sets_a: assert property ( // [R3]
		group_event && !report_mode_select_reg |=> group_ready_flag_o)
		else $error("ready flag not raised after valid group");

	ready_hold_a: assert property ( // [R3] [R9]
		$fell(flag_active) |-> $past(flag_len_reg) >= READY_CYC)
		else $error("ready flag dropped early");

	invalid_quiet_a: assert property ( // [R5]
		!report_mode_select_reg && group_i.done && !group_i.valid && !flag_active && !seek_event
		&& !pulse_active |=> !flag_active && !pulse_active)
		else $error("invalid group raised flag or pulse");

	disabled_quiet_a: assert property ( // [R1]
		!radio_data_enable_reg && !flag_active |=> !flag_active)
		else $error("group reported while decoding disabled");

	std_zero_a: assert property ( // [R6]
		rd_i && !report_mode_select_reg && (hit(addr_i, rdg_pkg::OFS_BLOCKS)
		|| hit(addr_i, rdg_pkg::OFS_STATUS)) |=> rdata_o[rdg_pkg::STAT_SYNC_BIT] == 1'b0
		&& rdata_o[7:1] == '0)
		else $error("verbose fields visible in standard mode");

	sync_follow_a: assert property ( // [R8]
		rd_i && report_mode_select_reg && hit(addr_i, rdg_pkg::OFS_STATUS)
		|=> rdata_o[rdg_pkg::STAT_SYNC_BIT] == $past(sync_i))
		else $error("sync flag does not follow sync");

	verbose_gate_a: assert property ( // [R10]
		report_mode_select_reg && group_i.done && !sync_i && !seek_event
		&& !pulse_active |=> !pulse_active)
		else $error("pin pulsed without sync");

	pin_low_a: assert property ( // [R4] [R17]
		pin_pulse_start && output_pin_function_reg == rdg_pkg::RDG_PIN_IRQ
		|=> pin_oe_o && !pin_out_o)
		else $error("pin not pulled low on event");

	pulse_hold_a: assert property ( // [R4] [R17]
		$fell(pulse_active) |-> $past(low_len_reg) >= PULSE_CYC)
		else $error("pin pulse too short");

	same_edge_a: assert property ( // [R18]
		group_event && group_irq_enable_reg |=> flag_active && pulse_active)
		else $error("pulse and flag not aligned");

	no_enable_a: assert property ( // [R18]
		!group_irq_enable_reg && !seek_done_irq_enable_reg && !pulse_active
		|=> !pulse_active)
		else $error("pin pulsed without enable");

	level_code_a: assert property ( // [R11]
		group_event && report_mode_select_reg && group_i.errs[0] >= 4'h6
		|=> block_level_reg[0] == rdg_pkg::LVL_MANY)
		else $error("block level encoding wrong");

	irq_out_a: assert property (
		irq_o == |(irq_stat_reg & irq_mask_reg))
		else $error("irq low with unmasked status");

	std_group_c: cover property (
		!report_mode_select_reg && group_event && group_irq_enable_reg);
	verbose_group_c: cover property (
		report_mode_select_reg && group_event && group_i.errs[3] == 4'h3);
	seek_pulse_c: cover property (
		seek_event && seek_done_irq_enable_reg
		&& output_pin_function_reg == rdg_pkg::RDG_PIN_IRQ);
	set_clear_c: cover property (|(irq_set & irq_clr));
endmodule
`default_nettype wire

// ---- bench/rdg_ctrl_model.sv ----
// controller-side model: pulled-up pin wire, interrupt pulse timing, block screening
`default_nettype none
module rdg_ctrl_model (
	input  wire logic        sys_clk_i,
	input  wire logic        pin_out_i,
	input  wire logic        pin_oe_i,
	input  wire logic        ext_en_i,
	input  wire logic        ext_val_i,
	input  wire logic [7:0]  level_i,
	output logic             pin_level_o,
	output logic [31:0]      low_len_o,
	output logic [31:0]      pulses_o,
	output logic [3:0]       usable_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [31:0] run_cnt;

	// pull-up wins when nobody drives the pin
	assign pin_level_o = pin_oe_i ? pin_out_i : (ext_en_i ? ext_val_i : 1'b1);

	initial begin
		run_cnt = 32'h0000_0000;
		low_len_o = 32'h0000_0000;
		pulses_o = 32'h0000_0000;
	end

	// measure each low period of the pin as one interrupt request
	always @(posedge sys_clk_i) begin
		if (pin_level_o === 1'b0) begin
			run_cnt <= run_cnt + 32'h1;
		end else begin
			if (run_cnt != 32'h0) begin
				low_len_o <= run_cnt;
				pulses_o <= pulses_o + 32'h1;
			end
			run_cnt <= 32'h0;
		end
	end

	// blocks at the top error level are dropped by the controller
	function automatic logic [3:0] usable(input logic [7:0] lv);
		for (int i = 0; i < 4; i++) begin
			usable[i] = (lv[2*i +: 2] != 2'b11);
		end
	endfunction

	assign usable_o = usable(level_i);
endmodule
`default_nettype wire

// ---- bench/rdg_top_test.sv ----
// self-checking bench for the radio data group status block
`default_nettype none
module rdg_top_test;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int RC = 20;
	localparam int PC = 5;
	logic                sys_clk = 1'b0;
	logic                resetn  = 1'b0;
	logic [7:0]          addr    = 8'h00;
	logic [15:0]         wdata   = 16'h0000;
	logic                wr      = 1'b0;
	logic                rd      = 1'b0;
	rdg_pkg::rdg_group_s grp     = '0;
	logic                sync    = 1'b0;
	logic                seek    = 1'b0;
	logic                ext_en  = 1'b0;
	logic                ext_val = 1'b1;
	logic [15:0]         rdata;
	logic                pin_lvl, pin_out, pin_oe, flag, irq;
	logic [31:0]         low_len, pulses;
	logic [3:0]          keep;
	int                  errors = 0;
	int                  check_count = 0;
	int                  cycles = 0;

	always #10 sys_clk = ~sys_clk;

	rdg_top #(.READY_CYC(RC), .PULSE_CYC(PC)) u_dut (
		.sys_clk_i(sys_clk), .resetn_i(resetn), .addr_i(addr), .wdata_i(wdata),
		.wr_i(wr), .rd_i(rd), .rdata_o(rdata), .group_i(grp), .sync_i(sync),
		.seek_done_i(seek), .pin_in_i(pin_lvl), .pin_out_o(pin_out), .pin_oe_o(pin_oe),
		.group_ready_flag_o(flag), .irq_o(irq));

	rdg_ctrl_model u_ctl (
		.sys_clk_i(sys_clk), .pin_out_i(pin_out), .pin_oe_i(pin_oe), .ext_en_i(ext_en),
		.ext_val_i(ext_val), .level_i(rdata[7:0]), .pin_level_o(pin_lvl),
		.low_len_o(low_len), .pulses_o(pulses), .usable_o(keep));

	task automatic close_out();
		$display("checks %0d errors %0d", check_count, errors);
		if (errors == 0 && check_count > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		check_count++;
		if (g !== e) begin
			errors++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic ticks(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask

	task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
		@(posedge sys_clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge sys_clk);
		wr <= 1'b0;
	endtask

	task automatic rd_chk(input string nm, input logic [7:0] a, input logic [15:0] e);
		@(posedge sys_clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge sys_clk);
		rd <= 1'b0;
		#1;
		chk(nm, e, rdata);
	endtask

	task automatic send(input logic v, input logic [15:0] e);
		@(posedge sys_clk);
		grp <= '{done: 1'b1, valid: v, errs: e};
		@(posedge sys_clk);
		grp.done <= 1'b0;
		#1;
	endtask

	task automatic t_reset();
		chk("flag", 16'h0, 16'(flag));
		chk("pin_oe", 16'h0, 16'(pin_oe));
		chk("irq", 16'h0, 16'(irq));
		rd_chk("ctrl", rdg_pkg::OFS_CTRL, 16'h0);
		rd_chk("mask", rdg_pkg::OFS_IRQ_MASK, 16'h0);
		wr_reg(8'h1c, 16'hffff);
		rd_chk("unmapped", 8'h1c, 16'h0);
		rd_chk("pin_cfg", rdg_pkg::OFS_PIN_CFG, 16'h0);
	endtask

	task automatic t_standard();
		int n;
		wr_reg(rdg_pkg::OFS_CTRL, 16'h0001);
		wr_reg(rdg_pkg::OFS_PIN_CFG, 16'h8004);
		wr_reg(rdg_pkg::OFS_IRQ_MASK, 16'h0001);
		sync <= 1'b1;
		send(1'b1, 16'h6521);
		chk("flag", 16'h1, 16'(flag));
		chk("pin_out", 16'h0, 16'(pin_out));
		chk("pin_oe", 16'h1, 16'(pin_oe));
		chk("irq", 16'h1, 16'(irq));
		n = 1;
		repeat (RC + 5) begin
			ticks(1);
			if (flag === 1'b1) n++;
		end
		chk("flag_len", 16'(RC), 16'(n));
		chk("pulse_len", 16'(PC), 16'(low_len));
		rd_chk("blocks", rdg_pkg::OFS_BLOCKS, 16'h0);
		rd_chk("status", rdg_pkg::OFS_STATUS, 16'h0001);
		rd_chk("irq_stat", rdg_pkg::OFS_IRQ_STAT, 16'h0001);
		wr_reg(rdg_pkg::OFS_IRQ_STAT, 16'h0001);
		rd_chk("irq_clr", rdg_pkg::OFS_IRQ_STAT, 16'h0);
		chk("irq_off", 16'h0, 16'(irq));
	endtask

	task automatic t_invalid();
		logic [31:0] p;
		p = pulses;
		send(1'b0, 16'h0000);
		chk("flag_bad", 16'h0, 16'(flag));
		ticks(PC + 2);
		chk("pulses_bad", 16'(p), 16'(pulses));
		rd_chk("stat_bad", rdg_pkg::OFS_IRQ_STAT, 16'h0);
		wr_reg(rdg_pkg::OFS_CTRL, 16'h0000);
		send(1'b1, 16'h0000);
		chk("flag_off", 16'h0, 16'(flag));
		ticks(PC + 2);
		chk("pulses_off", 16'(p), 16'(pulses));
	endtask

	task automatic t_verbose();
		logic [15:0] errs_t [2] = '{16'h6520, 16'h3417};
		logic [15:0] lvl_t [2] = '{16'h00e4, 16'h00a7};
		logic [3:0]  keep_t [2] = '{4'h7, 4'he};
		logic [31:0] p;
		wr_reg(rdg_pkg::OFS_CTRL, 16'h0003);
		sync <= 1'b0;
		send(1'b1, 16'h0000);
		chk("flag_nosync", 16'h0, 16'(flag));
		rd_chk("status_nosync", rdg_pkg::OFS_STATUS, 16'h0001);
		@(posedge sys_clk);
		sync <= 1'b1;
		rd_chk("status_sync", rdg_pkg::OFS_STATUS, 16'h0201);
		for (int i = 0; i < 2; i++) begin
			p = pulses;
			send(1'b1, errs_t[i]);
			chk("flag_v", 16'h1, 16'(flag));
			chk("pin_v", 16'h0, 16'(pin_out));
			rd_chk("levels", rdg_pkg::OFS_BLOCKS, lvl_t[i]);
			chk("usable", 16'(keep_t[i]), 16'(keep));
			ticks(RC + 2);
			chk("pulses_v", 16'(p + 32'h1), 16'(pulses));
		end
		@(posedge sys_clk);
		sync <= 1'b0;
		rd_chk("status_lost", rdg_pkg::OFS_STATUS, 16'h0001);
	endtask

	task automatic t_seek();
		logic [31:0] p;
		wr_reg(rdg_pkg::OFS_PIN_CFG, 16'h4004);
		wr_reg(rdg_pkg::OFS_IRQ_STAT, 16'h0003);
		wr_reg(rdg_pkg::OFS_IRQ_MASK, 16'h0002);
		p = pulses;
		seek <= 1'b1;
		ticks(1);
		chk("pin_seek", 16'h0, 16'(pin_out));
		chk("irq_seek", 16'h1, 16'(irq));
		ticks(PC + 2);
		chk("seek_len", 16'(PC), 16'(low_len));
		chk("seek_pulses", 16'(p + 32'h1), 16'(pulses));
		rd_chk("stat_seek", rdg_pkg::OFS_IRQ_STAT, 16'h0002);
		rd_chk("status_seek", rdg_pkg::OFS_STATUS, 16'h4001);
		wr_reg(rdg_pkg::OFS_IRQ_MASK, 16'h0000);
		seek <= 1'b0;
		ticks(1);
		chk("irq_masked", 16'h0, 16'(irq));
		wr_reg(rdg_pkg::OFS_IRQ_STAT, 16'h0002);
		// clear and new seek event on one edge: the set must win
		fork
			wr_reg(rdg_pkg::OFS_IRQ_STAT, 16'h0002);
			begin
				@(posedge sys_clk);
				seek <= 1'b1;
				@(posedge sys_clk);
				seek <= 1'b0;
			end
		join
		rd_chk("set_wins", rdg_pkg::OFS_IRQ_STAT, 16'h0002);
	endtask

	task automatic t_pinfn();
		logic [31:0] p;
		wr_reg(rdg_pkg::OFS_CTRL, 16'h0000);
		wr_reg(rdg_pkg::OFS_PIN_CFG, 16'h0008);
		#1;
		chk("fn_low", 16'h2, 16'({pin_oe, pin_out}));
		wr_reg(rdg_pkg::OFS_PIN_CFG, 16'h000c);
		#1;
		chk("fn_high", 16'h3, 16'({pin_oe, pin_out}));
		wr_reg(rdg_pkg::OFS_PIN_CFG, 16'h0000);
		ext_en <= 1'b1;
		ext_val <= 1'b0;
		ticks(1);
		chk("fn_off", 16'h0, 16'(pin_oe));
		ticks(3);
		rd_chk("pin_input", rdg_pkg::OFS_STATUS, 16'h0000);
		@(posedge sys_clk);
		ext_en <= 1'b0;
		wr_reg(rdg_pkg::OFS_CTRL, 16'h0001);
		wr_reg(rdg_pkg::OFS_PIN_CFG, 16'h0004);
		p = pulses;
		send(1'b1, 16'h0000);
		chk("flag_noie", 16'h1, 16'(flag));
		ticks(PC + 2);
		chk("pulses_noie", 16'(p), 16'(pulses));
		wr_reg(rdg_pkg::OFS_PIN_CFG, 16'h8000);
		send(1'b1, 16'h0000);
		chk("oe_nofn", 16'h0, 16'(pin_oe));
	endtask

	initial begin
		repeat (20) @(posedge sys_clk);
		resetn <= 1'b1;
		// settle before the pin serves as interrupt
		ticks(4);
		t_reset();
		t_standard();
		t_invalid();
		t_verbose();
		t_seek();
		t_pinfn();
		close_out();
	end

	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 3000) begin
			errors++;
			close_out();
		end
	end
endmodule
`default_nettype wire
